// File: rtl/baud_irq_out.sv
// Baud generator with prescaler and bus-style interrupt output stage
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "baud_irq_params.svh"
module baud_irq_out #(
    parameter int NUM_SOURCES = 4
) (
    // Clock and reset
    input  wire logic                   clk_in,
    input  wire logic                   sys_rst_in,
    // Register port
    input  wire logic [2:0]             reg_addr_in,
    input  wire logic [7:0]             reg_wdata_in,
    input  wire logic                   reg_write_in,
    input  wire logic                   reg_read_in,
    output logic      [7:0]             reg_rdata_out,
    // Strap pins
    input  wire logic                   bus_style_select_in,
    input  wire logic                   pc_decode_select_in,
    input  wire logic                   irq_route_select_in,
    // Internal interrupt sources
    input  wire logic [NUM_SOURCES-1:0] irq_source_in,
    // Interrupt pin, three signals
    output logic                        irq_line_out,
    output logic                        irq_line_oe_n_out,
    output logic                        irq_pending_out,
    // Sixteen-times sample enable
    output logic                        sample_tick_out,
    output logic [1:0]                  bus_mode_out
);
    import baud_irq_pkg::*;

    default clocking mon_clk @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);

    // Enable and status registers are one byte wide
    if (NUM_SOURCES < 1 || NUM_SOURCES > 8)
    begin : g_bad_sources
        $error("NUM_SOURCES must be 1..8");
    end

    //----------------------------------------------------------------
    // Registers
    //----------------------------------------------------------------
    logic [7:0]             div_low;
    logic [7:0]             div_high;
    logic [7:0]             modem_control_reg;
    logic [NUM_SOURCES-1:0] irq_enable;
    logic [2:0]             straps;
    logic [NUM_SOURCES-1:0] src_sync;

    // Straps and sources come from outside this clock domain
    pin_sync #(.WIDTH(3)) strap_sync (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .async_in   ({irq_route_select_in, pc_decode_select_in,
                      bus_style_select_in}),
        .sync_out   (straps)
    );

    pin_sync #(.WIDTH(NUM_SOURCES)) src_sync_u (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .async_in   (irq_source_in),
        .sync_out   (src_sync)
    );

    wire wr_div_low  = reg_write_in && reg_addr_in == `REG_DIV_LOW;
    wire wr_div_high = reg_write_in && reg_addr_in == `REG_DIV_HIGH;
    wire wr_mcr      = reg_write_in && reg_addr_in == `REG_MODEM_CTRL;
    wire wr_ien      = reg_write_in && reg_addr_in == `REG_IRQ_ENABLE;
    wire div_write   = wr_div_low || wr_div_high;

    // Divisor bytes keep no reset: software must program them first
    always_ff @(posedge clk_in)
    begin
        if (wr_div_low)
            div_low <= reg_wdata_in;
        if (wr_div_high)
            div_high <= reg_wdata_in;
    end

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            modem_control_reg <= `MCR_RESET;
            irq_enable        <= '0;
        end
        else
        begin
            if (wr_mcr)
                modem_control_reg <= reg_wdata_in;
            if (wr_ien)
                irq_enable <= reg_wdata_in[NUM_SOURCES-1:0];
        end
    end

    //----------------------------------------------------------------
    // Read path
    //----------------------------------------------------------------
    bus_mode_t mode;
    logic      pending;
    wire [7:0] ien_wide  = 8'(irq_enable);
    wire [7:0] stat_word = {5'h00, pending, bus_mode_out};
    wire [7:0] next_rdata =
        (reg_addr_in == `REG_DIV_LOW)    ? div_low :
        (reg_addr_in == `REG_DIV_HIGH)   ? div_high :
        (reg_addr_in == `REG_MODEM_CTRL) ? modem_control_reg :
        (reg_addr_in == `REG_IRQ_ENABLE) ? ien_wide :
        (reg_addr_in == `REG_STATUS)     ? stat_word : 8'h00;

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            reg_rdata_out <= 8'h00;
        else if (reg_read_in)
            reg_rdata_out <= next_rdata;
        else
            reg_rdata_out <= 8'h00;
    end

    //----------------------------------------------------------------
    // Prescaler and baud generator
    //----------------------------------------------------------------
    // clk_in stands for the oscillator input clock
    logic [1:0]  pre_cnt;
    logic [15:0] baud_cnt;
    wire  [15:0] divisor   = {div_high, div_low};
    wire         pre_div4  = modem_control_reg[`MCR_PRESCALE_BIT];
    wire         pre_tick  = !pre_div4 || pre_cnt == `PRESCALE_DIV4;
    // Divisor zero is outside range; treated as one to keep ticking
    wire         baud_wrap = baud_cnt <= 16'h0001;
    // No tick in a divisor write cycle, so a restart never doubles one
    wire         next_tick = pre_tick && baud_wrap && !div_write;

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            pre_cnt <= 2'h0;
        else if (!pre_div4)
            pre_cnt <= 2'h0;
        else
            pre_cnt <= pre_cnt + 2'h1;
    end

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            baud_cnt <= 16'h0001;
        else if (div_write)
            baud_cnt <= 16'h0001;
        else if (pre_tick)
            baud_cnt <= baud_wrap ? divisor : baud_cnt - 16'h0001;
    end

    // Single enable feeds both transmitter and receiver
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            sample_tick_out <= 1'b0;
        else
            sample_tick_out <= next_tick;
    end

    //----------------------------------------------------------------
    // Interrupt output stage
    //----------------------------------------------------------------
    assign mode    = bus_mode_t'({straps[1], straps[0]});
    assign pending = |(src_sync & irq_enable);
    wire route    = straps[2];
    wire irq_type = modem_control_reg[`MCR_IRQ_TYPE_BIT];
    wire irq_en   = modem_control_reg[`MCR_IRQ_EN_BIT];

    logic next_line;
    logic next_oe_n;

    always_comb
    begin
        next_line = 1'b0;
        next_oe_n = 1'b1;
        case (mode)
            MODE_STROBE:
            begin
                next_line = pending;
                next_oe_n = irq_type && !pending;
            end
            MODE_RW:
            begin
                next_line = 1'b0;
                next_oe_n = irq_type || !pending;
            end
            MODE_PC:
            begin
                next_line = pending;
                if (!route || !irq_en)
                    next_oe_n = 1'b1;
                else
                    next_oe_n = irq_type && !pending;
            end
            default:
            begin
                next_line = 1'b0;
                next_oe_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            irq_line_out      <= 1'b0;
            irq_line_oe_n_out <= 1'b1;
            irq_pending_out   <= 1'b0;
            bus_mode_out      <= 2'b00;
        end
        else
        begin
            irq_line_out      <= next_line;
            irq_line_oe_n_out <= next_oe_n;
            irq_pending_out   <= pending;
            bus_mode_out      <= mode;
        end
    end

    //----------------------------------------------------------------
    // Assertions
    //----------------------------------------------------------------
    strobe_low_a: assert property (
        mode == MODE_STROBE && !irq_type && !pending
        |=> !irq_line_out && !irq_line_oe_n_out)
        else $error("strobe mode idle not driven low");

    strobe_high_a: assert property (
        mode == MODE_STROBE && !irq_type && pending
        |=> irq_line_out && !irq_line_oe_n_out)
        else $error("strobe mode pending not driven high");

    strobe_share_a: assert property (
        mode == MODE_STROBE && irq_type && !pending |=> irq_line_oe_n_out)
        else $error("strobe shared idle not floating");

    strobe_pend_a: assert property (
        mode == MODE_STROBE && irq_type && pending
        |=> irq_line_out && !irq_line_oe_n_out)
        else $error("strobe shared pending not driven high");

    rw_pull_a: assert property (
        mode == MODE_RW && !irq_type && pending
        |=> !irq_line_out && !irq_line_oe_n_out)
        else $error("rw mode pending not pulled low");

    rw_float_a: assert property (
        mode == MODE_RW && irq_type |=> irq_line_oe_n_out)
        else $error("rw mode shared not floating");

    rw_idle_a: assert property (
        mode == MODE_RW && !pending |=> irq_line_oe_n_out)
        else $error("rw mode idle not floating");

    pc_float_a: assert property (
        mode == MODE_PC && (!route || !irq_en) |=> irq_line_oe_n_out)
        else $error("pc mode line not floating");

    pc_drive_a: assert property (
        mode == MODE_PC && route && irq_en && !irq_type
        |=> !irq_line_oe_n_out && irq_line_out == $past(pending))
        else $error("pc mode drive wrong");

    pc_share_a: assert property (
        mode == MODE_PC && route && irq_en && irq_type && !pending
        |=> irq_line_oe_n_out)
        else $error("pc shared idle not floating");

    pending_high_a: assert property (
        mode == MODE_PC && route && irq_en && pending
        |=> irq_line_out && !irq_line_oe_n_out)
        else $error("pc mode pending not high");

    bad_mode_a: assert property (
        mode == MODE_BAD |=> irq_line_oe_n_out)
        else $error("unused strap code not floating");

    pending_src_a: assert property (
        irq_pending_out == $past(|(src_sync & irq_enable)))
        else $error("pending flag mismatch");

    //----------------------------------------------------------------
    // Tick spacing monitor
    //----------------------------------------------------------------
    // Any control write voids the count: the next gap is partial
    logic [17:0] gap_cnt;
    logic        gap_valid;
    wire         ctl_write = div_write || wr_mcr;
    wire  [17:0] want_gap  = pre_div4 ? {divisor, 2'b00} : {2'b00, divisor};

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            gap_cnt   <= 18'h00000;
            gap_valid <= 1'b0;
        end
        else if (ctl_write)
        begin
            gap_cnt   <= 18'h00000;
            gap_valid <= 1'b0;
        end
        else if (sample_tick_out)
        begin
            gap_cnt   <= 18'h00001;
            gap_valid <= 1'b1;
        end
        else
        begin
            gap_cnt <= gap_cnt + 18'h00001;
        end
    end

    tick_div1_a: assert property (
        sample_tick_out && !pre_div4 && divisor == 16'h0003
        && $stable(divisor) ##0 !wr_div_low && !wr_div_high && !wr_mcr
        |=> !sample_tick_out ##1 !sample_tick_out)
        else $error("tick spacing wrong for divisor three");

    // A prescale clear just after a tick legally brings the next one early
    tick_div4_a: assert property (
        sample_tick_out && pre_div4 && divisor == 16'h0001 && !wr_mcr
        |=> (!sample_tick_out || !pre_div4) [*3])
        else $error("prescale by four spacing wrong");

    // Divisor zero is out of range and left unchecked
    tick_gap_a: assert property (
        gap_valid && sample_tick_out && divisor != 16'h0000
        |-> gap_cnt == want_gap)
        else $error("tick spacing differs from divisor and prescale");

    strobe_cov: cover property (@(posedge clk_in)
        mode == MODE_STROBE && pending);
    rw_cov: cover property (@(posedge clk_in)
        mode == MODE_RW && !irq_type && pending);
    pc_cov: cover property (@(posedge clk_in)
        mode == MODE_PC && route && irq_en && irq_type && pending);
    tick_cov: cover property (@(posedge clk_in)
        sample_tick_out && pre_div4);
    gap_cov: cover property (@(posedge clk_in)
        gap_valid && sample_tick_out && divisor == 16'h0900);
endmodule : baud_irq_out

// File: rtl/baud_irq_params.svh
// Constants for the baud clock and interrupt output block
//--------------------------------------------------------------------
//--------------------------------------------------------------------
`ifndef BAUD_IRQ_PARAMS_SVH
`define BAUD_IRQ_PARAMS_SVH

`define REG_DIV_LOW          3'h0
`define REG_DIV_HIGH         3'h1
`define REG_MODEM_CTRL       3'h4
`define REG_IRQ_ENABLE       3'h2
`define REG_STATUS           3'h5
`define MCR_IRQ_EN_BIT       3
`define MCR_IRQ_TYPE_BIT     5
`define MCR_PRESCALE_BIT     7
`define MCR_RESET            8'h00
`define PRESCALE_DIV4        2'h3
`define SAMPLES_PER_BIT      16

`endif

// File: rtl/baud_irq_pkg.sv
// Types for the baud clock and interrupt output block
package baud_irq_pkg;
    typedef enum logic [1:0]
    {
        MODE_PC     = 2'b00,
        MODE_STROBE = 2'b10,
        MODE_RW     = 2'b11,
        MODE_BAD    = 2'b01
    } bus_mode_t;
endpackage : baud_irq_pkg

// File: rtl/pin_sync.sv
// Two flip-flop synchroniser for strap and status pins
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             sys_rst_in,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage_one;

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            stage_one <= '0;
            sync_out  <= '0;
        end
        else
        begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end
endmodule : pin_sync

// File: sim/host_cpu.sv
// Host processor model driving the register port
`timescale 1ns/1ps
`include "baud_irq_params.svh"
module host_cpu #(
    parameter int CLK_HZ = 40000000
) (
    // Clock
    input  wire logic       clk_in,
    // Register port
    output logic      [2:0] reg_addr_out,
    output logic      [7:0] reg_wdata_out,
    output logic            reg_write_out,
    output logic            reg_read_out,
    input  wire logic [7:0] reg_rdata_in
);
    initial
    begin
        reg_addr_out  = 3'h0;
        reg_wdata_out = 8'h00;
        reg_write_out = 1'b0;
        reg_read_out  = 1'b0;
    end

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_addr_out  <= a;
        reg_wdata_out <= d;
        reg_write_out <= 1'b1;
        @(posedge clk_in);
        reg_write_out <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_in);
        reg_addr_out <= a;
        reg_read_out <= 1'b1;
        @(posedge clk_in);
        reg_read_out <= 1'b0;
        #1 d = reg_rdata_in;
    endtask : rd

    // Divisor is unknown after reset, so both bytes always go out
    task automatic set_div(input logic [15:0] d);
        wr(`REG_DIV_LOW, d[7:0]);
        wr(`REG_DIV_HIGH, d[15:8]);
    endtask : set_div

    task automatic set_rate(input int rate, input logic pre);
        int div;
        div = CLK_HZ / (pre ? 4 : 1) / (16 * rate);
        wr(`REG_MODEM_CTRL, {pre, 7'h00});
        set_div(div[15:0]);
    endtask : set_rate
endmodule : host_cpu

// File: sim/uart_baud_clock_and_irq_output_bench.sv
// Self-checking bench for the baud clock and interrupt output block
`timescale 1ns/1ps
`include "baud_irq_params.svh"
module uart_baud_clock_and_irq_output_bench;
    import baud_irq_pkg::*;
    logic       clk_in;
    logic       sys_rst_in;
    wire  [2:0] reg_addr;
    wire  [7:0] reg_wdata;
    wire        reg_write;
    wire        reg_read;
    wire  [7:0] reg_rdata;
    logic       bus_sel;
    logic       pc_sel;
    logic       route;
    logic [3:0] src;
    logic       irq_line_out;
    logic       irq_line_oe_n_out;
    logic       irq_pending_out;
    logic       sample_tick_out;
    logic [1:0] bus_mode_out;
    logic [7:0] rd;
    int         errors;
    int         compares;
    int         seed;
    int         gap;

    host_cpu u_host (.clk_in(clk_in), .reg_addr_out(reg_addr),
        .reg_wdata_out(reg_wdata), .reg_write_out(reg_write),
        .reg_read_out(reg_read), .reg_rdata_in(reg_rdata));

    baud_irq_out #(.NUM_SOURCES(4)) u_dut (.clk_in(clk_in),
        .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_write_in(reg_write),
        .reg_read_in(reg_read), .reg_rdata_out(reg_rdata),
        .bus_style_select_in(bus_sel), .pc_decode_select_in(pc_sel),
        .irq_route_select_in(route), .irq_source_in(src),
        .irq_line_out(irq_line_out), .irq_line_oe_n_out(irq_line_oe_n_out),
        .irq_pending_out(irq_pending_out),
        .sample_tick_out(sample_tick_out), .bus_mode_out(bus_mode_out));

    initial
    begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    task automatic chk(input string what, input logic [7:0] e,
                       input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic chk_gap(input int e, input int g);
        compares++;
        if (g != e)
        begin
            errors++;
            $display("[FAIL] tick gap expected %0d seen %0d", e, g);
        end
    endtask : chk_gap

    task automatic results;
        $display("Counts: %0d compares, %0d errors", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results

    // Returns {oe_n, line}; line is ignored while floating
    function automatic logic [1:0] exp_pin(logic b, logic p, logic s,
                                           logic [7:0] m, logic q);
        if (!b && p)
            return (!m[5] || q) ? {1'b0, q} : 2'b10;
        if (b && p)
            return (!m[5] && q) ? 2'b00 : 2'b10;
        if (!b && !p && s && m[3])
            return (!m[5] || q) ? {1'b0, q} : 2'b10;
        return 2'b10;
    endfunction : exp_pin

    task automatic next_tick(output int g);
        g = 0;
        do
        begin
            @(negedge clk_in);
            g++;
        end
        while (sample_tick_out !== 1'b1 && g < 20000);
    endtask : next_tick

    // The divisor write restarts the count, so the first gap is partial; later ticks use the new divisor
    task automatic gap_case(input int div, input logic pre);
        int g;
        u_host.wr(`REG_MODEM_CTRL, {pre, 7'h00});
        u_host.set_div(div[15:0]);
        next_tick(g);
        next_tick(g);
        next_tick(g);
        chk_gap(div * (pre ? 4 : 1), g);
    endtask : gap_case

    task automatic pin_case(input logic b, input logic p, input logic s,
                            input logic [7:0] m, input logic q);
        logic [1:0] e;
        u_host.wr(`REG_MODEM_CTRL, m);
        bus_sel <= b;
        pc_sel  <= p;
        route   <= s;
        src     <= q ? (4'($random(seed)) | 4'h1) : 4'h0;
        repeat (5) @(posedge clk_in);
        e = exp_pin(b, p, s, m, q);
        @(negedge clk_in);
        chk("pending", {7'h00, q}, {7'h00, irq_pending_out});
        chk("mode", {6'h00, p, b}, {6'h00, bus_mode_out});
        chk("oe_n", {7'h00, e[1]}, {7'h00, irq_line_oe_n_out});
        if (!e[1])
            chk("line", {7'h00, e[0]}, {7'h00, irq_line_out});
    endtask : pin_case

    initial
    begin
        #(25ns * 40000);
        errors++;
        results();
    end

    initial
    begin
        seed       = 24;
        errors     = 0;
        compares   = 0;
        sys_rst_in = 1'b1;
        bus_sel    = 1'b0;
        pc_sel     = 1'b1;
        route      = 1'b0;
        src        = 4'h0;
        repeat (16) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        // ----------------------------------------
        // Registers
        // ----------------------------------------
        u_host.set_div(16'h0900);
        u_host.rd(`REG_DIV_HIGH, rd);
        chk("div_high", 8'h09, rd);
        u_host.rd(`REG_DIV_LOW, rd);
        chk("div_low", 8'h00, rd);
        u_host.wr(3'h3, 8'hA5);
        u_host.rd(3'h3, rd);
        chk("unmapped", 8'h00, rd);
        u_host.wr(`REG_MODEM_CTRL, 8'hA8);
        u_host.rd(`REG_MODEM_CTRL, rd);
        chk("modem_ctrl", 8'hA8, rd);
        $display("Test registers done");
        // ----------------------------------------
        // Baud ticks
        // ----------------------------------------
        gap_case(2304, 1'b0);
        for (int d = 1; d <= 4; d = d * 2)
            for (int p = 0; p < 2; p++)
                gap_case(d, p[0]);
        gap_case(3, 1'b0);
        u_host.set_rate(625000, 1'b1);
        next_tick(gap);
        next_tick(gap);
        next_tick(gap);
        chk_gap(4, gap);
        $display("Test baud done");
        // ----------------------------------------
        // Interrupt pin
        // ----------------------------------------
        u_host.wr(`REG_IRQ_ENABLE, 8'h0F);
        u_host.rd(`REG_IRQ_ENABLE, rd);
        chk("irq_enable", 8'h0F, rd);
        for (int i = 0; i < 64; i++)
            pin_case(i[0], i[1], i[2], {2'h0, i[3], 1'b0, i[4], 3'h0},
                     i[5]);
        u_host.wr(`REG_IRQ_ENABLE, 8'h00);
        pin_case(1'b0, 1'b1, 1'b0, 8'h00, 1'b0);
        @(posedge clk_in);
        src <= 4'hF;
        repeat (5) @(posedge clk_in);
        @(negedge clk_in);
        chk("masked", 8'h00, {7'h00, irq_pending_out});
        u_host.wr(`REG_IRQ_ENABLE, 8'h0F);
        repeat (5) @(posedge clk_in);
        u_host.rd(`REG_STATUS, rd);
        chk("status", 8'h06, rd);
        $display("Test interrupt pin done");
        results();
    end
endmodule : uart_baud_clock_and_irq_output_bench
